// ==== verilog/dma_engine_consts.vh ====
// constants shared by the transfer engine and its per-controller arbiter
`ifndef DMA_ENGINE_CONSTS_VH
`define DMA_ENGINE_CONSTS_VH

`define CH_PER_CTRL   7
`define NUM_CH        14
`define PRIO_W        2
`define CNT_W         17
`define MAX_COUNT     17'h10000
`define SIZE_BYTE     2'b00
`define SIZE_HALF     2'b01
`define SIZE_WORD     2'b10
`define ST_IDLE       2'b00
`define ST_READ       2'b01
`define ST_WR_ISSUE   2'b10
`define ST_WRITE      2'b11

`endif

// ==== verilog/channel_arbiter.v ====
// priority arbiter for the seven channels of one controller
`timescale 1ns/1ps
`default_nettype none
`include "dma_engine_consts.vh"

module channel_arbiter #(
	parameter N_CH = `CH_PER_CTRL
) (
	input  wire [N_CH-1:0]           pend,
	input  wire [N_CH*`PRIO_W-1:0]   prio,
	output reg                       gnt_valid,
	output reg  [2:0]                gnt_idx
);

	reg [`PRIO_W-1:0] best;
	integer           i;

	// scan downward so an equal level at a lower index overwrites the pick
	always @* begin
		gnt_valid = 1'b0;
		gnt_idx   = 3'h0;
		best      = {`PRIO_W{1'b0}};
		for (i = N_CH - 1; i >= 0; i = i - 1) begin
			if (pend[i] && (!gnt_valid || prio[i*`PRIO_W +: `PRIO_W] >= best)) begin
				gnt_valid = 1'b1;
				gnt_idx   = i[2:0];
				best      = prio[i*`PRIO_W +: `PRIO_W];
			end
		end
	end

endmodule
`default_nettype wire

// ==== verilog/multi_channel_dma_engine.v ====
// fourteen-channel transfer engine: request router, two arbiters, bus mover
`timescale 1ns/1ps
`default_nettype none
`include "dma_engine_consts.vh"

module multi_channel_dma_engine #(
	parameter N_REQ  = 24,
	parameter N_TRIG = 8
) (
	input  wire                       clk,
	input  wire                       rst_n,
	input  wire [N_REQ-1:0]           periph_req,
	input  wire [N_TRIG-1:0]          hw_trig,
	input  wire [`NUM_CH-1:0]         ch_enable,
	input  wire [`NUM_CH-1:0]         ch_mem2mem,
	input  wire [`NUM_CH-1:0]         ch_circular,
	input  wire [`NUM_CH-1:0]         ch_src_inc,
	input  wire [`NUM_CH-1:0]         ch_dst_inc,
	input  wire [`NUM_CH*5-1:0]       ch_req_sel,
	input  wire [`NUM_CH*2-1:0]       ch_prio,
	input  wire [`NUM_CH*2-1:0]       ch_src_size,
	input  wire [`NUM_CH*2-1:0]       ch_dst_size,
	input  wire [`NUM_CH*32-1:0]      ch_src_addr,
	input  wire [`NUM_CH*32-1:0]      ch_dst_addr,
	input  wire [`NUM_CH*`CNT_W-1:0]  ch_count,
	input  wire [`NUM_CH-1:0]         ch_flag_clr,
	output reg  [`NUM_CH-1:0]         ch_req_ack_q,
	output reg  [`NUM_CH-1:0]         ch_half_q,
	output reg  [`NUM_CH-1:0]         ch_done_q,
	output reg  [`NUM_CH-1:0]         ch_err_q,
	output reg  [`NUM_CH-1:0]         ch_irq_q,
	output reg  [`NUM_CH-1:0]         ch_busy_q,
	output reg                        bus_req_q,
	output reg                        bus_we_q,
	output reg  [31:0]                bus_addr_q,
	output reg  [1:0]                 bus_size_q,
	output reg  [31:0]                bus_wdata_q,
	input  wire                       bus_ack,
	input  wire                       bus_err,
	input  wire [31:0]                bus_rdata
);

	// per-channel running state
	reg [31:0]        src_q   [0:`NUM_CH-1];
	reg [31:0]        dst_q   [0:`NUM_CH-1];
	reg [`CNT_W-1:0]  rem_q   [0:`NUM_CH-1];
	reg [`NUM_CH-1:0] en_q;
	reg [1:0]         state_q;
	reg [3:0]         ch_q;
	reg               turn_q;
	reg [`NUM_CH-1:0] set_half_d;
	reg [`NUM_CH-1:0] set_done_d;
	reg [`NUM_CH-1:0] set_err_d;
	reg [`NUM_CH-1:0] ack_d;

	// two-entry buffer between read and write sides
	reg [31:0]        buf_mem [0:1];
	reg               buf_wp_q;
	reg               buf_rp_q;
	reg [1:0]         buf_cnt_q;
	wire              buf_in_rdy  = (buf_cnt_q != 2'h2);
	wire              buf_out_vld = (buf_cnt_q != 2'h0);
	wire              buf_push    = (state_q == `ST_READ) && bus_ack && !bus_err;
	wire              buf_pop     = (state_q == `ST_WR_ISSUE) && buf_out_vld;

	// router: peripheral requests then triggers, any onto any channel
	wire [N_REQ+N_TRIG-1:0] route_src = {hw_trig, periph_req};
	reg  [`NUM_CH-1:0]      pend;
	integer                 k;

	// a channel asks for service while active, with items left and a request (a mem2mem channel needs none)
	always @* begin
		pend = {`NUM_CH{1'b0}};
		for (k = 0; k < `NUM_CH; k = k + 1) begin
			if (ch_busy_q[k] && rem_q[k] != {`CNT_W{1'b0}} && !(state_q != `ST_IDLE && ch_q == k[3:0])) begin
				if (ch_mem2mem[k])
					pend[k] = 1'b1;
				else if (ch_req_sel[k*5 +: 5] < N_REQ + N_TRIG)
					pend[k] = route_src[ch_req_sel[k*5 +: 5]];
			end
		end
	end

	wire       g0_vld;
	wire       g1_vld;
	wire [2:0] g0_idx;
	wire [2:0] g1_idx;

	// one arbiter per controller
	channel_arbiter #(.N_CH(`CH_PER_CTRL)) u_arb_first (
		.pend      (pend[`CH_PER_CTRL-1:0]),
		.prio      (ch_prio[`CH_PER_CTRL*2-1:0]),
		.gnt_valid (g0_vld),
		.gnt_idx   (g0_idx)
	);

	channel_arbiter #(.N_CH(`CH_PER_CTRL)) u_arb_second (
		.pend      (pend[`NUM_CH-1:`CH_PER_CTRL]),
		.prio      (ch_prio[`NUM_CH*2-1:`CH_PER_CTRL*2]),
		.gnt_valid (g1_vld),
		.gnt_idx   (g1_idx)
	);

	// controllers share the one master port, alternating when both ask
	wire       pick_second = g1_vld && (!g0_vld || turn_q);
	wire [3:0] sel_ch      = pick_second ? (4'h7 + {1'b0, g1_idx}) : {1'b0, g0_idx};
	wire       sel_vld     = g0_vld || g1_vld;

	// fit data into a width: narrower is truncated, wider is zero-padded
	function [31:0] fit;
		input [31:0] d;
		input [1:0]  sz;
		begin
			case (sz)
				`SIZE_BYTE: fit = {24'h000000, d[7:0]};
				`SIZE_HALF: fit = {16'h0000, d[15:0]};
				default:    fit = d;
			endcase
		end
	endfunction

	// address step in bytes for a width
	function [31:0] step;
		input [1:0] sz;
		begin
			case (sz)
				`SIZE_BYTE: step = 32'h00000001;
				`SIZE_HALF: step = 32'h00000002;
				default:    step = 32'h00000004;
			endcase
		end
	endfunction

	// buffer storage and pointers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_wp_q   <= 1'b0;
			buf_rp_q   <= 1'b0;
			buf_cnt_q  <= 2'h0;
			buf_mem[0] <= 32'h00000000;
			buf_mem[1] <= 32'h00000000;
		end else begin
			if (buf_push) begin
				buf_mem[buf_wp_q] <= fit(bus_rdata, bus_size_q);
				buf_wp_q          <= ~buf_wp_q;
			end
			if (buf_pop)
				buf_rp_q <= ~buf_rp_q;
			if (buf_push && !buf_pop)
				buf_cnt_q <= buf_cnt_q + 2'h1;
			else if (buf_pop && !buf_push)
				buf_cnt_q <= buf_cnt_q - 2'h1;
		end
	end

	// count left after this write, and the block size clamped as at arming
	wire [`CNT_W-1:0] rem_m1 = rem_q[ch_q] - {{(`CNT_W-1){1'b0}}, 1'b1};
	wire [`CNT_W-1:0] total  = (ch_count[ch_q*`CNT_W +: `CNT_W] > `MAX_COUNT) ?
	                           `MAX_COUNT : ch_count[ch_q*`CNT_W +: `CNT_W];
	integer           ci;

	// mover: one source read, one destination write per item
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= `ST_IDLE;
			ch_q        <= 4'h0;
			turn_q      <= 1'b0;
			en_q        <= {`NUM_CH{1'b0}};
			ch_busy_q   <= {`NUM_CH{1'b0}};
			bus_req_q   <= 1'b0;
			bus_we_q    <= 1'b0;
			bus_addr_q  <= 32'h00000000;
			bus_size_q  <= 2'h0;
			bus_wdata_q <= 32'h00000000;
			set_half_d  <= {`NUM_CH{1'b0}};
			set_done_d  <= {`NUM_CH{1'b0}};
			set_err_d   <= {`NUM_CH{1'b0}};
			ack_d       <= {`NUM_CH{1'b0}};
			for (ci = 0; ci < `NUM_CH; ci = ci + 1) begin
				src_q[ci] <= 32'h00000000;
				dst_q[ci] <= 32'h00000000;
				rem_q[ci] <= {`CNT_W{1'b0}};
			end
		end else begin
			set_half_d <= {`NUM_CH{1'b0}};
			set_done_d <= {`NUM_CH{1'b0}};
			set_err_d  <= {`NUM_CH{1'b0}};
			ack_d      <= {`NUM_CH{1'b0}};
			en_q       <= ch_enable;
			case (state_q)
				`ST_IDLE: begin
					// back-pressure: no read unless the buffer has room
					if (sel_vld && buf_in_rdy) begin
						ch_q       <= sel_ch;
						turn_q     <= (g0_vld && g1_vld) ? ~turn_q : turn_q;
						bus_req_q  <= 1'b1;
						bus_we_q   <= 1'b0;
						bus_addr_q <= src_q[sel_ch];
						bus_size_q <= ch_src_size[sel_ch*2 +: 2];
						state_q    <= `ST_READ;
					end
				end
				`ST_READ: begin
					if (bus_ack) begin
						bus_req_q <= 1'b0;
						if (bus_err) begin
							set_err_d[ch_q] <= 1'b1;
							ch_busy_q[ch_q] <= 1'b0;
							state_q         <= `ST_IDLE;
						end else begin
							state_q <= `ST_WR_ISSUE;
						end
					end
				end
				`ST_WR_ISSUE: begin
					if (buf_out_vld) begin
						bus_req_q   <= 1'b1;
						bus_we_q    <= 1'b1;
						bus_addr_q  <= dst_q[ch_q];
						bus_size_q  <= ch_dst_size[ch_q*2 +: 2];
						bus_wdata_q <= fit(buf_mem[buf_rp_q], ch_dst_size[ch_q*2 +: 2]);
						state_q     <= `ST_WRITE;
					end
				end
				`ST_WRITE: begin
					if (bus_ack) begin
						bus_req_q    <= 1'b0;
						state_q      <= `ST_IDLE;
						if (bus_err) begin
							set_err_d[ch_q] <= 1'b1;
							ch_busy_q[ch_q] <= 1'b0;
						end else begin
							// a refused write is no finished item, so no ack
							ack_d[ch_q] <= 1'b1;
							rem_q[ch_q] <= rem_m1;
							if (ch_src_inc[ch_q])
								src_q[ch_q] <= src_q[ch_q] + step(ch_src_size[ch_q*2 +: 2]);
							if (ch_dst_inc[ch_q])
								dst_q[ch_q] <= dst_q[ch_q] + step(ch_dst_size[ch_q*2 +: 2]);
							if (rem_m1 == (total >> 1))
								set_half_d[ch_q] <= 1'b1;
							if (rem_m1 == {`CNT_W{1'b0}}) begin
								set_done_d[ch_q] <= 1'b1;
								if (ch_circular[ch_q]) begin
									rem_q[ch_q] <= total;
									src_q[ch_q] <= ch_src_addr[ch_q*32 +: 32];
									dst_q[ch_q] <= ch_dst_addr[ch_q*32 +: 32];
								end else begin
									ch_busy_q[ch_q] <= 1'b0;
								end
							end
						end
					end
				end
				default: state_q <= `ST_IDLE;
			endcase
			// enable rise loads the programmed block, drop stops the channel
			for (ci = 0; ci < `NUM_CH; ci = ci + 1) begin
				if (ch_enable[ci] && !en_q[ci]) begin
					ch_busy_q[ci] <= 1'b1;
					src_q[ci]     <= ch_src_addr[ci*32 +: 32];
					dst_q[ci]     <= ch_dst_addr[ci*32 +: 32];
					rem_q[ci]     <= (ch_count[ci*`CNT_W +: `CNT_W] > `MAX_COUNT) ?
					                 `MAX_COUNT : ch_count[ci*`CNT_W +: `CNT_W];
				end else if (!ch_enable[ci]) begin
					ch_busy_q[ci] <= 1'b0;
				end
			end
		end
	end

	// sticky flags; a set in the clear cycle wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ch_half_q    <= {`NUM_CH{1'b0}};
			ch_done_q    <= {`NUM_CH{1'b0}};
			ch_err_q     <= {`NUM_CH{1'b0}};
			ch_irq_q     <= {`NUM_CH{1'b0}};
			ch_req_ack_q <= {`NUM_CH{1'b0}};
		end else begin
			ch_half_q    <= set_half_d | (ch_half_q & ~ch_flag_clr);
			ch_done_q    <= set_done_d | (ch_done_q & ~ch_flag_clr);
			ch_err_q     <= set_err_d | (ch_err_q & ~ch_flag_clr);
			ch_irq_q     <= set_half_d | set_done_d | set_err_d |
			                ((ch_half_q | ch_done_q | ch_err_q) & ~ch_flag_clr);
			ch_req_ack_q <= ack_d;
		end
	end

endmodule
`default_nettype wire

// ==== dv/dma_monitor.sv ====
// bus and flag checker for the transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "dma_engine_consts.vh"
module dma_monitor (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic [`NUM_CH-1:0] ch_flag_clr,
	input wire logic [`NUM_CH-1:0] ch_req_ack_q,
	input wire logic [`NUM_CH-1:0] ch_half_q,
	input wire logic [`NUM_CH-1:0] ch_done_q,
	input wire logic [`NUM_CH-1:0] ch_err_q,
	input wire logic [`NUM_CH-1:0] ch_irq_q,
	input wire logic               bus_req_q,
	input wire logic               bus_we_q,
	input wire logic [31:0]        bus_addr_q,
	input wire logic               bus_ack,
	input wire logic               bus_err
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a request stays put until answered, then drops for a cycle
	req_hold_a: assert property (bus_req_q && !bus_ack |=> bus_req_q && $stable(bus_addr_q) && $stable(bus_we_q))
		else $error("bus request changed before ack");
	req_drop_a: assert property (bus_req_q && bus_ack |=> !bus_req_q)
		else $error("no idle cycle after ack");
	irq_or_a: assert property (ch_irq_q == (ch_half_q | ch_done_q | ch_err_q))
		else $error("irq is not the or of the flags");
	done_sticky_a: assert property (1'b1 |=> ($past(ch_done_q) & ~$past(ch_flag_clr) & ~ch_done_q) == '0)
		else $error("done flag lost without clear");
	done_cause_a: assert property (
		((ch_done_q | ch_half_q) & ~$past(ch_done_q | ch_half_q) & ~ch_req_ack_q) == '0)
		else $error("half or done set without item");
	// flags and acks come two edges after the bus answer: set pulse, then output
	err_cause_a: assert property (|(ch_err_q & ~$past(ch_err_q)) |-> $past(bus_req_q && bus_ack && bus_err, 2))
		else $error("error flag without bus error");
	ack_cause_a: assert property (|ch_req_ack_q |-> $past(bus_req_q && bus_ack && bus_we_q && !bus_err, 2))
		else $error("item ack without write ack");
	ack_single_a: assert property ($onehot0(ch_req_ack_q))
		else $error("two channels acked at once");
	cover property (|ch_half_q);
	cover property (|ch_done_q);
	cover property (|ch_err_q);
endmodule
`default_nettype wire

// ==== dv/mem_model.sv ====
// behavioural memory answering the engine's bus accesses
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        req,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] bad_addr,
	output var  logic        ack,
	output var  logic        err,
	output var  logic [31:0] rdata
);
	logic [1:0] wait_q;
	// answer after one or three cycles; data is scrambled outside ack so stale words never match
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'h0;
			err <= 1'h0;
			rdata <= 32'h0;
			wait_q <= 2'h0;
		end else begin
			ack <= 1'h0;
			err <= 1'h0;
			rdata <= ~rdata;
			if (req && !ack) begin
				if (wait_q == (slow ? 2'h2 : 2'h0)) begin
					ack <= 1'h1;
					err <= (addr == bad_addr);
					rdata <= {addr[15:0], ~addr[15:0]};
					wait_q <= 2'h0;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the fourteen-channel transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "dma_engine_consts.vh"
module testbench;
	logic                      clk, rst_n, slow, req, we, ack, berr;
	logic [23:0]               preq;
	logic [7:0]                trig;
	logic [`NUM_CH-1:0]        en, m2m, circ, fclr, rack, half, done, err, irq, busy, sinc, dinc;
	logic [`NUM_CH*5-1:0]      sel;
	logic [`NUM_CH*2-1:0]      prio, ssz, dsz;
	logic [`NUM_CH*32-1:0]     sa, da;
	logic [`NUM_CH*`CNT_W-1:0] cnt;
	logic [31:0]               addr, wdata, rdata;
	logic [1:0]                bsz;
	logic [31:0]               wa[$], wd[$], ra[$];
	logic [1:0]                sz[$];
	int                        err_count, checks_done, acks;
	multi_channel_dma_engine u_multi_channel_dma_engine (.clk(clk), .rst_n(rst_n), .periph_req(preq),
		.hw_trig(trig), .ch_enable(en), .ch_mem2mem(m2m), .ch_circular(circ), .ch_src_inc(sinc),
		.ch_dst_inc(dinc), .ch_req_sel(sel), .ch_prio(prio), .ch_src_size(ssz), .ch_dst_size(dsz),
		.ch_src_addr(sa), .ch_dst_addr(da), .ch_count(cnt), .ch_flag_clr(fclr), .ch_req_ack_q(rack),
		.ch_half_q(half), .ch_done_q(done), .ch_err_q(err), .ch_irq_q(irq), .ch_busy_q(busy),
		.bus_req_q(req), .bus_we_q(we), .bus_addr_q(addr), .bus_size_q(bsz), .bus_wdata_q(wdata),
		.bus_ack(ack), .bus_err(berr), .bus_rdata(rdata));
	mem_model u_mem_model (.clk(clk), .rst_n(rst_n), .slow(slow), .req(req), .addr(addr),
		.bad_addr(32'h0000bad0), .ack(ack), .err(berr), .rdata(rdata));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// log every answered access
	always @(posedge clk) begin
		if (req && ack && we) begin
			wa.push_back(addr);
			wd.push_back(wdata);
		end
		if (req && ack && !we) ra.push_back(addr);
		if (req && ack) sz.push_back(bsz);
		if (|rack) acks++;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cfg(input int c, input logic mm, input logic ci, input logic [4:0] s, input logic [1:0] p,
		input logic [1:0] ss, input logic [1:0] ds, input logic [31:0] a, input logic [31:0] d, input int n);
		m2m[c] <= mm;
		circ[c] <= ci;
		sel[c*5+:5] <= s;
		prio[c*2+:2] <= p;
		ssz[c*2+:2] <= ss;
		dsz[c*2+:2] <= ds;
		sa[c*32+:32] <= a;
		da[c*32+:32] <= d;
		cnt[c*17+:17] <= n[16:0];
		@(posedge clk);
	endtask
	// arm, wait for done or error on every channel of the mask
	task automatic go(input logic [`NUM_CH-1:0] m);
		int t;
		en <= en | m;
		for (t = 0; t < 3000; t++) begin
			@(posedge clk);
			if (((done | err) & m) === m) break;
		end
		chk("go_wait", 1, t < 3000);
	endtask
	// disarm, let an in-flight item finish, then clear the flags
	task automatic off();
		en <= '0;
		repeat (20) @(posedge clk);
		fclr <= '1;
		@(posedge clk);
		fclr <= '0;
		@(posedge clk);
		chk("half_done", 0, {half, done});
		chk("err_irq_clr", 0, {err, irq});
		chk("acks", wa.size(), acks);
		wa.delete();
		wd.delete();
		ra.delete();
		sz.delete();
		acks = 0;
	endtask
	task automatic complete_run();
		if (err_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(25 * 40000);
		err_count++;
		complete_run();
	end
	initial begin
		int w;
		{rst_n, slow, preq, trig, en, m2m, circ, fclr, sel, prio, ssz, dsz, sa, da, cnt} = '0;
		sinc = '1;
		dinc = '1;
		acks = 0;
		err_count = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		// word reads cut into byte writes, with a fast and a stalling memory
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			cfg(0, 1, 0, 0, 0, `SIZE_WORD, `SIZE_BYTE, 32'h100, 32'h200, 4);
			go(14'h1);
			chk("items", 4, wa.size());
			for (int i = 0; i < 4; i++) chk("dst", 32'h200 + i, wa[i]);
			for (int i = 0; i < 4; i++) chk("data", ~(32'h100 + 4 * i) & 32'hff, wd[i]);
			chk("rd_size", `SIZE_WORD, sz[0]);
			chk("wr_size", `SIZE_BYTE, sz[1]);
			chk("half", 1, half[0]);
			chk("irq", 1, irq[0]);
			chk("idle_busy", 0, busy[0]);
			off();
		end
		// priorities: very high first, equal levels by index
		cfg(1, 1, 0, 0, 0, `SIZE_WORD, `SIZE_WORD, 32'h300, 32'h900, 1);
		cfg(2, 1, 0, 0, 3, `SIZE_WORD, `SIZE_WORD, 32'h400, 32'h900, 1);
		cfg(3, 1, 0, 0, 1, `SIZE_WORD, `SIZE_WORD, 32'h500, 32'h900, 1);
		cfg(5, 1, 0, 0, 1, `SIZE_WORD, `SIZE_WORD, 32'h600, 32'h900, 1);
		go(14'h2e);
		chk("first", 32'h400, ra[0]);
		chk("second", 32'h500, ra[1]);
		chk("third", 32'h600, ra[2]);
		chk("fourth", 32'h300, ra[3]);
		off();
		// routed request and trigger on the second controller, one fixed side each
		cfg(8, 0, 0, 5'h05, 0, `SIZE_HALF, `SIZE_WORD, 32'ha00, 32'hb00, 2);
		cfg(12, 0, 0, 5'h1a, 0, `SIZE_HALF, `SIZE_WORD, 32'hc00, 32'hd00, 2);
		sinc[8] <= 0;
		dinc[12] <= 0;
		en <= 14'h1100;
		repeat (20) @(posedge clk);
		chk("idle", 0, ra.size());
		preq[5] <= 1;
		trig[2] <= 1;
		go(14'h1100);
		preq <= '0;
		trig <= '0;
		chk("routed", 4, wa.size());
		chk("half_wd", ~32'ha00 & 32'hffff, wd[0]);
		chk("fixed_src", 32'ha00, ra[1]);
		chk("trig_src", 32'hc02, ra[3]);
		chk("fixed_dst", 32'hd00, wa[3]);
		off();
		sinc <= '1;
		dinc <= '1;
		// bus error raises the error flag only
		cfg(4, 1, 0, 0, 0, `SIZE_WORD, `SIZE_WORD, 32'hbad0, 32'he00, 2);
		go(14'h10);
		chk("err", 1, err[4]);
		chk("err_irq", 1, irq[4]);
		chk("no_done", 0, done[4]);
		chk("err_busy", 0, busy[4]);
		chk("err_writes", 0, wa.size());
		off();
		// circular buffer wraps back to the start addresses
		cfg(6, 1, 1, 0, 0, `SIZE_WORD, `SIZE_HALF, 32'h700, 32'h800, 2);
		en <= 14'h40;
		for (w = 0; w < 400 && wa.size() < 5; w++) @(posedge clk);
		chk("wrap_wait", 1, w < 400);
		chk("circ_busy", 1, busy[6]);
		chk("wrap_dst", 32'h800, wa[2]);
		chk("wrap_next", 32'h802, wa[3]);
		chk("wrap_src", 32'h700, ra[4]);
		off();
		complete_run();
	end
endmodule
bind multi_channel_dma_engine dma_monitor u_dma_monitor (.clk, .rst_n, .ch_flag_clr, .ch_req_ack_q,
	.ch_half_q, .ch_done_q, .ch_err_q, .ch_irq_q, .bus_req_q, .bus_we_q, .bus_addr_q, .bus_ack, .bus_err);
`default_nettype wire
